// File: logic/init_seq_pkg.sv
// Purpose: Shared constants for the converter power-up and reset sequencer.
// Assumes: One 10 MHz clock that stands in for the sampling clock.
// Notes:   The reset pulse count is derived from its time and the clock rate.
package init_seq_pkg;

	localparam int unsigned CLK_HZ             = 10_000_000;
	localparam int unsigned CAL_CYCLES         = 200_000;
	localparam int unsigned CAL_W              = 18;
	localparam int unsigned FUSE_WORDS         = 4;
	localparam int unsigned FUSE_IDX_W         = 2;
	localparam int unsigned REG_W              = 8;
	localparam int unsigned RESET_PULSE_NS     = 1_000;
	localparam int unsigned CLK_PERIOD_NS      = 1_000_000_000 / CLK_HZ;
	localparam int unsigned RESET_PULSE_CYCLES =
		(RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_W            = 4;

	localparam logic [7:0] SW_RESET_ADDR = 8'h00;
	localparam int unsigned SW_RESET_BIT = 0;
	localparam logic [7:0] REG0_RESET    = 8'h00;

	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,
		ST_FUSE  = 2'b01,
		ST_CAL   = 2'b11,
		ST_READY = 2'b10
	} seq_state_e;

endpackage

// File: logic/fuse_loader.sv
// Purpose: Walks the fuse words into the default register image.
// Assumes: Same clock as the sequencer; start is a one-cycle pulse.
// Notes:   Done pulses one cycle after the last word is written.
`timescale 1ns/1ps
module fuse_loader (
	input  wire logic                                       i_mclk,
	input  wire logic                                       i_rstn,
	input  wire logic                                       i_start,
	output logic [init_seq_pkg::FUSE_IDX_W-1:0]             o_index,
	output logic                                            o_we,
	output logic                                            o_done
);
	import init_seq_pkg::*;

	logic busy_reg;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			busy_reg <= 1'b0;
			o_index  <= '0;
			o_done   <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				busy_reg <= 1'b1;
				o_index  <= '0;
			end else if (busy_reg) begin
				if (o_index == FUSE_IDX_W'(FUSE_WORDS - 1)) begin
					busy_reg <= 1'b0;
					o_done   <= 1'b1;
				end else begin
					o_index <= o_index + 1'b1;
				end
			end
		end
	end

	assign o_we = busy_reg;

endmodule // fuse_loader

// File: logic/adc_init_reset_sequencer.sv
// Purpose: Power-up and reset sequencing: reset pin, fuse load, calibration, soft reset.
// Assumes: Pin inputs are asynchronous; the SPI write strobe is on this clock.
// Notes on behaviour
// (RULE_01) Host waits 2 ms before strapping reference.
// (RULE_02) Host sets reference pin, clock before reset.
// (RULE_03) Host pulses reset high to default registers.
// (RULE_04) Reset release loads fuses, then starts calibration.
// (RULE_05) Calibration lasts 200000 sampling-clock cycles.
// (RULE_06) Host waits 200000 cycles before serial programming.
// (RULE_07) Defaults restorable by pin pulse or command.
// (RULE_08) Writing one to bit 0, address 0 resets.
// (RULE_09) Soft reset bit clears itself afterwards.
// (RULE_10) Host keeps reset pin low during soft reset.
// (RULE_11) Host keeps sampling clock running through calibration.
`timescale 1ns/1ps
module adc_init_reset_sequencer (
	input  wire logic                                  i_mclk,
	input  wire logic                                  i_rstn,
	input  wire logic                                  i_reset_pin,
	input  wire logic                                  i_reference_buffer_select_pin,
	input  wire logic                                  i_wr_en,
	input  wire logic [7:0]                            i_wr_addr,
	input  wire logic [init_seq_pkg::REG_W-1:0]        i_wr_data,
	input  wire logic [init_seq_pkg::REG_W-1:0]        i_fuse_data,
	output logic [init_seq_pkg::FUSE_IDX_W-1:0]        o_fuse_index,
	output logic [init_seq_pkg::REG_W*init_seq_pkg::FUSE_WORDS-1:0] o_defaults,
	output logic                                       o_defaults_we,
	output logic                                       o_reg_clear,
	output logic                                       o_sw_reset_bit,
	output logic                                       o_ref_select,
	output logic                                       o_cal_busy,
	output logic                                       o_ready
);
	import init_seq_pkg::*;

	logic             rst_meta_reg, rst_sync_reg;
	logic             ref_meta_reg, ref_sync_reg;
	logic             sw_req;
	logic             fuse_start_reg;
	logic             fuse_done;
	logic             fuse_we;
	logic             load_we;
	logic             restart;
	logic [CAL_W-1:0] cal_cnt_reg;
	seq_state_e       state_reg, state_next;

	function automatic logic is_sw_reset(input logic en, input logic [7:0] addr,
		input logic [REG_W-1:0] data);
		return en && (addr == SW_RESET_ADDR) && data[SW_RESET_BIT];
	endfunction

	// Both pins pass two flops; only the second flop of each is read by the logic.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
			ref_meta_reg <= 1'b0;
			ref_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= i_reset_pin;
			rst_sync_reg <= rst_meta_reg;
			ref_meta_reg <= i_reference_buffer_select_pin;
			ref_sync_reg <= ref_meta_reg;
		end
	end

	// The strap level is sampled while reset is held; it must be stable by then.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ref_select <= 1'b0;
		end else if (rst_sync_reg) begin
			o_ref_select <= ref_sync_reg; // RULE_02
		end
	end

	// Commands are ignored while the pin reset is high; the host keeps it low.
	assign sw_req = is_sw_reset(i_wr_en, i_wr_addr, i_wr_data) && !rst_sync_reg; // RULE_08 RULE_10
	assign restart = rst_sync_reg || sw_req;

	// A done pulse that meets the new start belongs to a cut run and is ignored.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_HOLD:  if (!rst_sync_reg) state_next = ST_FUSE;
			ST_FUSE:  if (fuse_done && !fuse_start_reg) state_next = ST_CAL; // RULE_04
			ST_CAL:   if (cal_cnt_reg == CAL_W'(CAL_CYCLES - 1)) state_next = ST_READY;
			ST_READY: state_next = ST_READY;
			default:  state_next = ST_HOLD;
		endcase
		if (restart) begin
			state_next = ST_HOLD; // RULE_07
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	// The start is a single pulse on the step from HOLD into FUSE.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			fuse_start_reg <= 1'b0;
		end else begin
			fuse_start_reg <= (state_reg == ST_HOLD) && (state_next == ST_FUSE); // RULE_04
		end
	end

	fuse_loader fuse_loader_inst (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_start (fuse_start_reg),
		.o_index (o_fuse_index),
		.o_we    (fuse_we),
		.o_done  (fuse_done)
	);

	// Byte k of the default image is taken from fuse word k.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_defaults <= '0;
		end else if (load_we) begin
			o_defaults[o_fuse_index*REG_W +: REG_W] <= i_fuse_data; // RULE_04
		end
	end

	// A loader still busy from a cut run is masked until the new start resets its index.
	assign load_we       = fuse_we && (state_reg == ST_FUSE) && !fuse_start_reg;
	assign o_defaults_we = load_we;

	// The count restarts from zero every time calibration is entered.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cal_cnt_reg <= '0;
		end else if (state_reg == ST_CAL) begin
			cal_cnt_reg <= cal_cnt_reg + 1'b1; // RULE_05
		end else begin
			cal_cnt_reg <= '0;
		end
	end

	// The bit reads one for exactly the cycle of the clear, then drops by itself.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sw_reset_bit <= REG0_RESET[SW_RESET_BIT];
			o_reg_clear    <= 1'b1;
		end else begin
			o_sw_reset_bit <= sw_req; // RULE_09
			o_reg_clear    <= restart; // RULE_07 RULE_08
		end
	end

	assign o_cal_busy = (state_reg == ST_CAL);
	assign o_ready    = (state_reg == ST_READY); // RULE_06

	// Checks on the sequence; each names the rule that it guards.
	a_cal_length: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_05
		(state_reg == ST_CAL && cal_cnt_reg == CAL_W'(CAL_CYCLES - 1) && !rst_sync_reg && !sw_req)
		|=> o_ready)
		else $error("calibration did not end at its count");
	a_cal_not_early: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_05
		$rose(o_ready) |-> $past(cal_cnt_reg) == CAL_W'(CAL_CYCLES - 1))
		else $error("ready rose before full calibration");
	a_fuse_before_cal: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_04
		$rose(o_cal_busy) |-> $past(fuse_done))
		else $error("calibration started without fuse load");
	a_release_loads: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_04
		(state_reg == ST_HOLD && !rst_sync_reg && !sw_req) |=> fuse_start_reg)
		else $error("reset release did not start fuse load");
	a_sw_clears: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_08
		sw_req |=> o_reg_clear && state_reg == ST_HOLD)
		else $error("soft reset did not clear registers");
	a_bit_selfclear: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_09
		(sw_req ##1 !sw_req) |=> !o_sw_reset_bit)
		else $error("soft reset bit stuck high");
	a_pin_resets: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_07
		rst_sync_reg |=> o_reg_clear && !o_ready && !o_cal_busy)
		else $error("pin reset did not hold sequencer");
	a_ready_holds: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_06
		(o_ready && !rst_sync_reg && !sw_req) |=> o_ready)
		else $error("ready dropped without reset");
	a_sw_bit_pulse: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_09
		sw_req |=> o_sw_reset_bit)
		else $error("soft reset bit did not read one");
	a_sw_refused: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_10
		(i_wr_en && rst_sync_reg) |=> !o_sw_reset_bit)
		else $error("soft reset taken while pin reset high");
	a_clear_release: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_07
		!restart |=> !o_reg_clear)
		else $error("register clear held without reset");
	a_ref_capture: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_02
		rst_sync_reg |=> o_ref_select == $past(ref_sync_reg))
		else $error("strap not captured during reset");
	a_ref_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_02
		!rst_sync_reg |=> $stable(o_ref_select))
		else $error("strap changed outside reset");

	a_load_from_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_04
		$rose(o_defaults_we) |-> o_fuse_index == '0)
		else $error("fuse load did not start at word zero");
	a_defaults_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_04
		!o_defaults_we |=> $stable(o_defaults))
		else $error("default image changed outside fuse load");
	a_fuse_then_cal: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_04
		(load_we && o_fuse_index == FUSE_IDX_W'(FUSE_WORDS - 1) && !restart) ##1 !restart
		|=> o_cal_busy)
		else $error("calibration did not follow the last fuse word");
	a_cal_counts: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_05
		(o_cal_busy && !restart && cal_cnt_reg != CAL_W'(CAL_CYCLES - 1))
		|=> (o_cal_busy && cal_cnt_reg == $past(cal_cnt_reg) + 1'b1))
		else $error("calibration count skipped a cycle");
	a_cal_start_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE_05
		$rose(o_cal_busy) |-> cal_cnt_reg == '0)
		else $error("calibration count did not start at zero");

	c_power_up: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(o_ready));
	c_fuse_load: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(o_defaults_we));
	c_ref_low: cover property (@(posedge i_mclk) disable iff (!i_rstn)
		rst_sync_reg && !ref_sync_reg);
	c_sw_reset: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_ready && sw_req);
	c_pin_in_cal: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_cal_busy && rst_sync_reg);

endmodule // adc_init_reset_sequencer

// File: tb/host_model.sv
// Purpose: Host model driving the reset pin, strap and register writes.
// Assumes: Drives on the falling clock edge; a write strobe lasts one cycle.
// Notes:   The strap toggles until the power-on delay has run out.
`timescale 1ns/1ps
module host_model (
	input  wire logic i_mclk,
	output logic      o_reset_pin,
	output logic      o_strap,
	output logic      o_wr_en,
	output logic [7:0] o_wr_addr,
	output logic [7:0] o_wr_data
);
	import init_seq_pkg::*;
	initial begin
		o_reset_pin = 1'b0;
		o_strap = 1'b0;
		o_wr_en = 1'b0;
		o_wr_addr = 8'h00;
		o_wr_data = 8'h00;
	end
	task automatic power_up(input logic level);
		repeat (2 * CLK_HZ / 1000) begin
			@(negedge i_mclk);
			o_strap <= ~o_strap;
		end
		o_strap <= level;
	endtask
	task automatic pulse_reset(input int cycles);
		@(negedge i_mclk);
		o_reset_pin <= 1'b1;
		repeat (cycles) @(negedge i_mclk);
		o_reset_pin <= 1'b0;
	endtask
	task automatic write(input logic [7:0] addr, input logic [7:0] data, input logic pin);
		@(negedge i_mclk);
		o_reset_pin <= pin;
		// The pin passes two flops in the sequencer, so the strobe waits for it.
		repeat (2) @(negedge i_mclk);
		o_wr_en <= 1'b1;
		o_wr_addr <= addr;
		o_wr_data <= data;
		@(negedge i_mclk);
		o_wr_en <= 1'b0;
		o_wr_addr <= ~addr;
		o_wr_data <= ~data;
	endtask
	task automatic strap(input logic level);
		@(negedge i_mclk);
		o_strap <= level;
	endtask
endmodule // host_model

// File: tb/adc_init_reset_sequencer_tb.sv
// Purpose: Self-checking bench for the power-up and reset sequencer.
// Assumes: Fuse words are random; the host model makes every pin move.
// Notes:   Four calibrations start; the second is timed in full, the first and third are cut short by a pin reset, and the run stops during the fourth.
`timescale 1ns/1ps
module adc_init_reset_sequencer_tb;
	import init_seq_pkg::*;
	logic i_mclk, i_rstn, pin, strap, wr_en, we, clr, swb, refs, busy, ready;
	logic [7:0] wa, wd;
	logic [REG_W-1:0] fuse [FUSE_WORDS];
	logic [FUSE_IDX_W-1:0] idx;
	logic [REG_W*FUSE_WORDS-1:0] dflt;
	logic [31:0] rng;
	int error_cnt, samples_checked;
	host_model host_model_inst (.i_mclk(i_mclk), .o_reset_pin(pin), .o_strap(strap),
		.o_wr_en(wr_en), .o_wr_addr(wa), .o_wr_data(wd));
	adc_init_reset_sequencer adc_init_reset_sequencer_inst (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_reset_pin(pin), .i_reference_buffer_select_pin(strap), .i_wr_en(wr_en),
		.i_wr_addr(wa), .i_wr_data(wd), .i_fuse_data(fuse[idx]), .o_fuse_index(idx),
		.o_defaults(dflt), .o_defaults_we(we), .o_reg_clear(clr), .o_sw_reset_bit(swb),
		.o_ref_select(refs), .o_cal_busy(busy), .o_ready(ready));
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic new_fuses();
		for (int k = 0; k < FUSE_WORDS; k++) begin
			rng = xorshift(rng);
			fuse[k] = rng[REG_W-1:0];
		end
	endtask
	task automatic check_load();
		logic [31:0] exp;
		int n;
		for (n = 0; we !== 1'b1 && n < 40; n++) @(negedge i_mclk);
		for (int k = 0; k < FUSE_WORDS; k++) begin
			chk("defaults_we", 1, we);
			chk("fuse_index", k, idx);
			exp[8*k +: 8] = fuse[k];
			@(negedge i_mclk);
		end
		chk("defaults_we", 0, we);
		for (n = 0; busy !== 1'b1 && n < 3; n++) @(negedge i_mclk);
		chk("cal_busy", 1, busy);
		chk("defaults", exp, dflt);
	endtask
	task automatic check_soft(input logic exp);
		int seen;
		seen = 0;
		// The bit stands one cycle and the reload starts two edges after the command.
		repeat (2) begin
			if (swb === 1'b1) seen++;
			if (swb === 1'b1) chk("reg_clear", 1, clr);
			@(negedge i_mclk);
		end
		chk("sw_pulses", exp, seen);
		chk("sw_bit", 0, swb);
	endtask
	initial begin
		int n;
		i_rstn = 1'b0;
		rng = 1;
		new_fuses();
		repeat (10) @(negedge i_mclk);
		chk("reg_clear", 1, clr);
		i_rstn = 1'b1;
		@(negedge i_mclk);
		chk("reg_clear", 0, clr);
		host_model_inst.power_up(1'b1);
		new_fuses();
		host_model_inst.pulse_reset(RESET_PULSE_CYCLES + 2);
		chk("reg_clear", 1, clr);
		chk("ref_select", 1, refs);
		check_load();
		for (n = 0; busy === 1'b1 && n < CAL_CYCLES + 10; n++) @(negedge i_mclk);
		chk("cal_cycles", CAL_CYCLES, n);
		chk("ready", 1, ready);
		new_fuses();
		for (int i = 0; i < 3; i++) begin
			host_model_inst.write(i == 0 ? 8'h01 : SW_RESET_ADDR, i == 1 ? 8'hfe : 8'h01, 0);
			check_soft(i == 2);
			chk("ready", i != 2, ready);
		end
		check_load();
		repeat (100) @(negedge i_mclk);
		new_fuses();
		host_model_inst.write(SW_RESET_ADDR, 8'h01, 1'b1);
		check_soft(1'b0);
		chk("reg_clear", 1, clr);
		host_model_inst.strap(1'b0);
		host_model_inst.pulse_reset(RESET_PULSE_CYCLES);
		chk("ref_select", 0, refs);
		check_load();
		report_and_stop();
	end
	initial begin
		repeat (2 * CLK_HZ / 1000 + CAL_CYCLES + 3000) @(posedge i_mclk);
		error_cnt++;
		report_and_stop();
	end
endmodule // adc_init_reset_sequencer_tb
